// [cfr_defines.svh]
// constants for the core register set and condition flags
// assumes inclusion by the core register file and its package users
`ifndef CFR_DEFINES_SVH
`define CFR_DEFINES_SVH
`define CFR_FLAG_CARRY 0
`define CFR_FLAG_ZERO 1
`define CFR_FLAG_SIGN 2
`define CFR_FLAG_IRQ_LO 3
`define CFR_FLAG_HALF 4
`define CFR_FLAG_IRQ_HI 5
`define CFR_FLAGS_RESET 8'hE8
`define CFR_IP_RESET 16'h0000
`define CFR_LEVEL_MAIN 2'h2
`define CFR_LEVEL_ONE 2'h1
`define CFR_LEVEL_TWO 2'h0
`define CFR_LEVEL_OFF 2'h3
`endif

// [cfr_pkg.sv]
// types for the core register set: operation codes and carriers
// assumes cfr_defines.svh holds the bit positions and reset values
package cfr_pkg;
  // register selector for moves, push and pop
  typedef enum logic [2:0] {
    CFR_SEL_ACC = 3'h0,
    CFR_SEL_IDX1 = 3'h1,
    CFR_SEL_IDX2 = 3'h2,
    CFR_SEL_IPL = 3'h3,
    CFR_SEL_IPH = 3'h4,
    CFR_SEL_FLAGS = 3'h5
  } cfr_sel_t;
  // flag update kind for the current instruction
  typedef enum logic [2:0] {
    CFR_FOP_NONE = 3'h0,
    CFR_FOP_ADD = 3'h1,
    CFR_FOP_ARITH = 3'h2,
    CFR_FOP_LOGIC = 3'h3,
    CFR_FOP_SHIFT = 3'h4,
    CFR_FOP_SET_C = 3'h5,
    CFR_FOP_CLR_C = 3'h6,
    CFR_FOP_BTJ = 3'h7
  } cfr_fop_t;
  // branch condition codes for relative jumps
  typedef enum logic [2:0] {
    CFR_JMP_HALF = 3'h0,
    CFR_JMP_NO_HALF = 3'h1,
    CFR_JMP_MINUS = 3'h2,
    CFR_JMP_PLUS = 3'h3,
    CFR_JMP_EQUAL = 3'h4,
    CFR_JMP_NOT_EQUAL = 3'h5,
    CFR_JMP_CARRY = 3'h6,
    CFR_JMP_NO_CARRY = 3'h7
  } cfr_jmp_t;
  // alu result with its side outputs
  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic half;
  } cfr_alu_t;
  // register write from the instruction sequencer
  typedef struct packed {
    logic en;
    cfr_sel_t sel;
    logic [7:0] data;
  } cfr_wr_t;
  // interrupt entry strobe and level from the interrupt sequencer
  typedef struct packed {
    logic enter;
    logic [1:0] level;
  } cfr_irq_t;
endpackage

// [cfr_core_regs.sv]
// programmer-visible core registers and the condition flag logic
// assumes an instruction sequencer drives the strobes on the same clock;
// registers have no memory address, only instructions reach them
`timescale 1ns/100ps
`include "cfr_defines.svh"

// Functional notes
// (RQ1) an 8-bit accumulator supplies ALU operands and takes ALU results.
// (RQ2) two 8-bit index registers hold addresses or temporary data.
// (RQ3) interrupt entry and exit never save or restore the second index register.
// (RQ4) the 16-bit instruction pointer is built from a low and a high byte register.
// (RQ5) the six core registers answer no memory address, only instruction ports.
// (RQ6) the flag register holds level bits and four flags, resetting to 111x1xxx.
// (RQ7) the flag register can be pushed and popped, and each flag tested and driven.
// (RQ8) half carry is set on carry from bit 3 to bit 4 in add, cleared otherwise.
// (RQ9) half carry is tested by one jump when set and one when clear.
// (RQ10) the sign flag copies bit 7 of every arithmetic, logic or data result.
// (RQ11) the zero flag is set when such a result is zero, cleared otherwise.
// (RQ12) the carry flag shows overflow or underflow of the last arithmetic.
// (RQ13) carry is forced by set and clear ops and updated by bit test, shift and rotate.
// (RQ14) sign, zero and carry each have one jump for set and one for clear.
// (RQ15) level bits 5 and 3 encode the priority: 10 is 0, 01 is 1, 00 is 2, 11 is 3.
// (RQ16) interrupt entry pushes instruction pointer, first index, accumulator, flags.
// (RQ17) flags not touched by an instruction keep their stored value.
module cfr_core_regs (
  input wire logic i_clk, // cpu clock
  input wire logic i_rst, // synchronous reset, active high
  input wire cfr_pkg::cfr_wr_t i_wr, // register write from instruction
  input wire cfr_pkg::cfr_fop_t i_fop, // flag update kind
  input wire cfr_pkg::cfr_alu_t i_alu, // alu result and side outputs
  input wire logic i_acc_load, // accumulator takes alu result
  input wire logic i_ip_load, // instruction pointer load
  input wire logic [15:0] i_ip_value, // value for pointer load
  input wire logic i_ip_inc, // advance pointer by one
  input wire logic i_level_wr, // software writes level bits
  input wire logic [1:0] i_level_value, // new level, high then low bit
  input wire cfr_pkg::cfr_irq_t i_irq, // interrupt entry strobe and level
  input wire cfr_pkg::cfr_jmp_t i_jmp_cond, // branch condition to evaluate
  input wire cfr_pkg::cfr_sel_t i_rd_sel, // register read selector
  output logic [7:0] o_acc, // accumulator
  output logic [7:0] o_idx1, // first index register
  output logic [7:0] o_idx2, // second index register
  output logic [15:0] o_ip, // instruction pointer
  output logic [7:0] o_flags, // condition flags register
  output logic o_jmp_taken, // branch condition result, registered
  output logic [7:0] o_rd_data, // selected register, registered
  output logic o_ctx_save // pulse: context saved on interrupt entry
);
  import cfr_pkg::*;

  logic [7:0] acc;
  logic [7:0] idx1;
  logic [7:0] idx2;
  logic [7:0] ip_low;
  logic [7:0] ip_high;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [15:0] ip_sum;
  logic jmp_now;

  // accumulator: alu results take priority over plain moves
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc <= 8'h00;
    end else if (i_acc_load) begin
      acc <= i_alu.value; // see (RQ1)
    end else if (i_wr.en && i_wr.sel == CFR_SEL_ACC) begin
      acc <= i_wr.data; // see (RQ1)
    end
  end

  // index registers; the second has no interrupt path at all, by design
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      idx1 <= 8'h00;
      idx2 <= 8'h00;
    end else if (i_wr.en) begin
      if (i_wr.sel == CFR_SEL_IDX1) begin
        idx1 <= i_wr.data; // see (RQ2)
      end
      if (i_wr.sel == CFR_SEL_IDX2) begin
        idx2 <= i_wr.data; // see (RQ2) see (RQ3)
      end
    end
  end

  // instruction pointer as two bytes, byte writes serve the pop on return
  assign ip_sum = {ip_high, ip_low} + 16'h0001;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {ip_high, ip_low} <= `CFR_IP_RESET; // both bytes from one 16-bit reset value
    end else if (i_ip_load) begin
      ip_low <= i_ip_value[7:0]; // see (RQ4)
      ip_high <= i_ip_value[15:8];
    end else if (i_wr.en && i_wr.sel == CFR_SEL_IPL) begin
      ip_low <= i_wr.data;
    end else if (i_wr.en && i_wr.sel == CFR_SEL_IPH) begin
      ip_high <= i_wr.data;
    end else if (i_ip_inc) begin
      ip_low <= ip_sum[7:0]; // see (RQ4)
      ip_high <= ip_sum[15:8];
    end
  end

  // next flag value; untouched bits hold, pop or interrupt entry win
  always_comb begin
    next_flags = flags; // see (RQ17)
    case (i_fop)
      CFR_FOP_ADD: begin
        next_flags[`CFR_FLAG_HALF] = i_alu.half; // see (RQ8)
        next_flags[`CFR_FLAG_SIGN] = i_alu.value[7]; // see (RQ10)
        next_flags[`CFR_FLAG_ZERO] = (i_alu.value == 8'h00); // see (RQ11)
        next_flags[`CFR_FLAG_CARRY] = i_alu.carry; // see (RQ12)
      end
      CFR_FOP_ARITH, CFR_FOP_SHIFT: begin
        next_flags[`CFR_FLAG_SIGN] = i_alu.value[7]; // see (RQ10)
        next_flags[`CFR_FLAG_ZERO] = (i_alu.value == 8'h00); // see (RQ11)
        next_flags[`CFR_FLAG_CARRY] = i_alu.carry; // see (RQ12) see (RQ13)
      end
      CFR_FOP_LOGIC: begin
        next_flags[`CFR_FLAG_SIGN] = i_alu.value[7]; // see (RQ10)
        next_flags[`CFR_FLAG_ZERO] = (i_alu.value == 8'h00); // see (RQ11)
      end
      CFR_FOP_SET_C: next_flags[`CFR_FLAG_CARRY] = 1'b1; // see (RQ13)
      CFR_FOP_CLR_C: next_flags[`CFR_FLAG_CARRY] = 1'b0; // see (RQ13)
      CFR_FOP_BTJ: next_flags[`CFR_FLAG_CARRY] = i_alu.carry; // see (RQ13)
      default: next_flags = flags;
    endcase
    if (i_level_wr) begin
      next_flags[`CFR_FLAG_IRQ_HI] = i_level_value[1]; // see (RQ15)
      next_flags[`CFR_FLAG_IRQ_LO] = i_level_value[0];
    end
    if (i_wr.en && i_wr.sel == CFR_SEL_FLAGS) begin
      next_flags = i_wr.data; // see (RQ7)
    end
    if (i_irq.enter) begin
      next_flags[`CFR_FLAG_IRQ_HI] = i_irq.level[1]; // see (RQ15)
      next_flags[`CFR_FLAG_IRQ_LO] = i_irq.level[0];
    end
  end

  // flag register; undefined reset bits are driven to zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags <= `CFR_FLAGS_RESET; // see (RQ6)
    end else begin
      flags <= next_flags;
    end
  end

  // branch condition, one test per flag state
  always_comb begin
    case (i_jmp_cond)
      CFR_JMP_HALF: jmp_now = flags[`CFR_FLAG_HALF]; // see (RQ9)
      CFR_JMP_NO_HALF: jmp_now = !flags[`CFR_FLAG_HALF]; // see (RQ9)
      CFR_JMP_MINUS: jmp_now = flags[`CFR_FLAG_SIGN]; // see (RQ14)
      CFR_JMP_PLUS: jmp_now = !flags[`CFR_FLAG_SIGN];
      CFR_JMP_EQUAL: jmp_now = flags[`CFR_FLAG_ZERO];
      CFR_JMP_NOT_EQUAL: jmp_now = !flags[`CFR_FLAG_ZERO];
      CFR_JMP_CARRY: jmp_now = flags[`CFR_FLAG_CARRY];
      default: jmp_now = !flags[`CFR_FLAG_CARRY];
    endcase
  end

  // registered read port and branch result; no address decode exists
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
      o_jmp_taken <= 1'b0;
    end else begin
      o_jmp_taken <= jmp_now;
      if (i_rd_sel == CFR_SEL_ACC) begin
        o_rd_data <= acc; // see (RQ5)
      end else if (i_rd_sel == CFR_SEL_IDX1) begin
        o_rd_data <= idx1;
      end else if (i_rd_sel == CFR_SEL_IDX2) begin
        o_rd_data <= idx2;
      end else if (i_rd_sel == CFR_SEL_IPL) begin
        o_rd_data <= ip_low;
      end else if (i_rd_sel == CFR_SEL_IPH) begin
        o_rd_data <= ip_high;
      end else begin
        o_rd_data <= flags; // see (RQ7)
      end
    end
  end

  // entry pulse tells the stacker to push pointer, idx1, acc, flags
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ctx_save <= 1'b0;
    end else begin
      o_ctx_save <= i_irq.enter; // see (RQ16)
    end
  end

  assign o_acc = acc;
  assign o_idx1 = idx1;
  assign o_idx2 = idx2;
  assign o_ip = {ip_high, ip_low};
  assign o_flags = flags;

  a_flags_reset: assert property (@(posedge i_clk) i_rst |=> o_flags == 8'hE8) // see (RQ6)
    else $error("flags wrong after reset");
  a_half_carry: assert property (@(posedge i_clk) disable iff (i_rst) // see (RQ8)
    (i_fop == CFR_FOP_ADD && !i_wr.en) |=> o_flags[4] == $past(i_alu.half))
    else $error("half carry not taken from add");
  a_sign_copy: assert property (@(posedge i_clk) disable iff (i_rst) // see (RQ10)
    (i_fop inside {CFR_FOP_ADD, CFR_FOP_LOGIC} && !i_wr.en) |=> o_flags[2] == $past(i_alu.value[7]))
    else $error("sign flag not result bit 7");
  a_zero_flag: assert property (@(posedge i_clk) disable iff (i_rst) // see (RQ11)
    (i_fop == CFR_FOP_LOGIC && !i_wr.en) |=> o_flags[1] == ($past(i_alu.value) == 8'h00))
    else $error("zero flag wrong");
  a_carry_force: assert property (@(posedge i_clk) disable iff (i_rst) // see (RQ13)
    (i_fop == CFR_FOP_SET_C && !i_wr.en) |=> o_flags[0])
    else $error("set carry failed");
  a_flags_hold: assert property (@(posedge i_clk) disable iff (i_rst) // see (RQ17)
    (i_fop == CFR_FOP_NONE && !i_wr.en && !i_level_wr && !i_irq.enter) |=> $stable(o_flags))
    else $error("flags changed without cause");
  a_idx2_keep: assert property (@(posedge i_clk) disable iff (i_rst) // see (RQ3)
    (i_irq.enter && !i_wr.en) |=> $stable(o_idx2))
    else $error("second index disturbed by interrupt");
  a_jump_carry: assert property (@(posedge i_clk) disable iff (i_rst) // see (RQ14)
    (i_jmp_cond == CFR_JMP_NO_CARRY) |=> o_jmp_taken == !$past(o_flags[0]))
    else $error("carry jump wrong");
  a_irq_level: assert property (@(posedge i_clk) disable iff (i_rst) // see (RQ15)
    i_irq.enter |=> o_flags[5] == $past(i_irq.level[1]) && o_flags[3] == $past(i_irq.level[0])
      && o_ctx_save)
    else $error("interrupt level or save pulse wrong");
  c_add_half: cover property (@(posedge i_clk) i_fop == CFR_FOP_ADD && i_alu.half);
  c_irq_entry: cover property (@(posedge i_clk) i_irq.enter);
  c_pop_flags: cover property (@(posedge i_clk) i_wr.en && i_wr.sel == CFR_SEL_FLAGS);
  c_jump_taken: cover property (@(posedge i_clk) o_jmp_taken);
endmodule

// [tb.sv]
// self-checking bench for the core register set, driven by random instruction strobes
// assumes cfr_core_regs runs alone on one clock with a synchronous active-high reset
`timescale 1ns/100ps
module tb;
  import cfr_pkg::*;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx1;
    logic [7:0] idx2;
    logic [15:0] ip;
    logic [7:0] flags;
    logic jmp;
    logic [7:0] rd;
    logic ctx;
  } cfr_exp_t;
  logic i_clk, i_rst, i_acc_load, i_ip_load, i_ip_inc, i_level_wr;
  cfr_wr_t i_wr;
  cfr_fop_t i_fop;
  cfr_alu_t i_alu;
  logic [15:0] i_ip_value, o_ip;
  logic [1:0] i_level_value;
  cfr_irq_t i_irq;
  cfr_jmp_t i_jmp_cond;
  cfr_sel_t i_rd_sel;
  logic [7:0] o_acc, o_idx1, o_idx2, o_flags, o_rd_data;
  logic o_jmp_taken, o_ctx_save;
  logic [31:0] seed = 32'h135CBCF8;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  cfr_exp_t model, e;
  cfr_exp_t exp_q[$];

  cfr_core_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_fop(i_fop), .i_alu(i_alu),
    .i_acc_load(i_acc_load), .i_ip_load(i_ip_load), .i_ip_value(i_ip_value),
    .i_ip_inc(i_ip_inc), .i_level_wr(i_level_wr), .i_level_value(i_level_value),
    .i_irq(i_irq), .i_jmp_cond(i_jmp_cond), .i_rd_sel(i_rd_sel), .o_acc(o_acc),
    .o_idx1(o_idx1), .o_idx2(o_idx2), .o_ip(o_ip), .o_flags(o_flags),
    .o_jmp_taken(o_jmp_taken), .o_rd_data(o_rd_data), .o_ctx_save(o_ctx_save));

  // free-running cpu clock, 8 ns period
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // reference of one edge; later assignments win, matching the stated priorities
  function automatic cfr_exp_t step(input cfr_exp_t m);
    cfr_exp_t n;
    logic [2:0] jc;
    logic [7:0] f;
    n = m;
    jc = i_jmp_cond;
    f = m.flags;
    // branch and read look at the register values before this edge
    case (jc[2:1])
      2'h0: n.jmp = m.flags[4] ^ jc[0];
      2'h1: n.jmp = m.flags[2] ^ jc[0];
      2'h2: n.jmp = m.flags[1] ^ jc[0];
      default: n.jmp = m.flags[0] ^ jc[0];
    endcase
    case (i_rd_sel)
      CFR_SEL_ACC: n.rd = m.acc;
      CFR_SEL_IDX1: n.rd = m.idx1;
      CFR_SEL_IDX2: n.rd = m.idx2;
      CFR_SEL_IPL: n.rd = m.ip[7:0];
      CFR_SEL_IPH: n.rd = m.ip[15:8];
      default: n.rd = m.flags;
    endcase
    n.ctx = i_irq.enter;
    if (i_fop inside {CFR_FOP_ADD, CFR_FOP_ARITH, CFR_FOP_LOGIC, CFR_FOP_SHIFT}) begin
      f[2] = i_alu.value[7];
      f[1] = (i_alu.value == 8'h00);
    end
    if (i_fop == CFR_FOP_ADD) f[4] = i_alu.half;
    if (i_fop inside {CFR_FOP_ADD, CFR_FOP_ARITH, CFR_FOP_SHIFT, CFR_FOP_BTJ}) begin
      f[0] = i_alu.carry;
    end
    if (i_fop == CFR_FOP_SET_C) f[0] = 1'b1;
    if (i_fop == CFR_FOP_CLR_C) f[0] = 1'b0;
    if (i_level_wr) {f[5], f[3]} = i_level_value;
    if (i_wr.en && i_wr.sel == CFR_SEL_FLAGS) f = i_wr.data;
    if (i_irq.enter) {f[5], f[3]} = i_irq.level;
    n.flags = f;
    if (i_wr.en && i_wr.sel == CFR_SEL_ACC) n.acc = i_wr.data;
    if (i_acc_load) n.acc = i_alu.value;
    if (i_wr.en && i_wr.sel == CFR_SEL_IDX1) n.idx1 = i_wr.data;
    if (i_wr.en && i_wr.sel == CFR_SEL_IDX2) n.idx2 = i_wr.data;
    // a byte write on the pointer replaces the increment in that cycle, both bytes
    if (i_ip_inc && !(i_wr.en && i_wr.sel inside {CFR_SEL_IPL, CFR_SEL_IPH})) begin
      n.ip = m.ip + 16'h0001;
    end
    if (i_wr.en && i_wr.sel == CFR_SEL_IPH) n.ip[15:8] = i_wr.data;
    if (i_wr.en && i_wr.sel == CFR_SEL_IPL) n.ip[7:0] = i_wr.data;
    if (i_ip_load) n.ip = i_ip_value;
    return n;
  endfunction

  // one cycle of random strobes; selector codes 6 and 7 exercise ignored writes
  task automatic drive(input logic rst);
    logic [31:0] a, b, c;
    a = rnd();
    b = rnd();
    c = rnd();
    i_rst = rst;
    i_wr = {a[0], a[3:1], a[11:4]};
    i_fop = cfr_fop_t'(a[14:12]);
    i_alu = {((a[15] & a[26]) ? 8'h00 : a[23:16]), a[24], a[25]};
    i_acc_load = a[27] & a[28];
    i_ip_load = b[0] & b[1] & b[2];
    i_ip_value = b[31:16];
    i_ip_inc = b[3];
    i_level_wr = b[4] & b[5];
    i_level_value = b[7:6];
    i_irq = {b[8] & b[9] & b[10], b[12:11]};
    i_jmp_cond = cfr_jmp_t'(c[2:0]);
    i_rd_sel = cfr_sel_t'(c[5:3]);
    // undefined reset bits of the flags are taken as zero, giving 111x1xxx as E8
    if (rst) model = '{acc: 8'h00, idx1: 8'h00, idx2: 8'h00, ip: 16'h0000, flags: 8'hE8,
      jmp: 1'b0, rd: 8'h00, ctx: 1'b0};
    else model = step(model);
    exp_q.push_back(model);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watcher: every edge answers the oldest note, at the first edge after its strobes
  always @(posedge i_clk) begin
    #1;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({8'h00, o_acc}, {8'h00, e.acc}, "accumulator");
      chk({8'h00, o_idx1}, {8'h00, e.idx1}, "index one");
      chk({8'h00, o_idx2}, {8'h00, e.idx2}, "index two");
      chk(o_ip, e.ip, "pointer");
      chk({8'h00, o_flags}, {8'h00, e.flags}, "flags");
      chk({15'h0000, o_jmp_taken}, {15'h0000, e.jmp}, "branch");
      chk({8'h00, o_rd_data}, {8'h00, e.rd}, "read data");
      chk({15'h0000, o_ctx_save}, {15'h0000, e.ctx}, "context save");
    end
  end

  // hang guard, well above the 3000-odd cycles of the sequence
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // reset, a long random run with a second reset in mid-run, then the verdict
  initial begin
    i_rst = 1'b1;
    i_wr = '0;
    i_fop = CFR_FOP_NONE;
    i_alu = '0;
    i_acc_load = 1'b0;
    i_ip_load = 1'b0;
    i_ip_value = 16'h0000;
    i_ip_inc = 1'b0;
    i_level_wr = 1'b0;
    i_level_value = 2'h0;
    i_irq = '0;
    i_jmp_cond = CFR_JMP_HALF;
    i_rd_sel = CFR_SEL_ACC;
    repeat (12) @(negedge i_clk) drive(1'b1);
    for (int k = 0; k < 3000; k++) @(negedge i_clk) drive(k >= 1500 && k < 1502);
    repeat (3) @(posedge i_clk);
    #2;
    report_and_stop();
  end
endmodule
